/* omcc_mode_ctrl.sv */
`timescale 1ns/10ps
// What this block does
// - idle off at power-down with detector and watchdog disabled enters deep stop; all clocks and watchdog stop
// - low-voltage detect enabled blocks deep stop entry
// - stop with subclock keeps sub clock while detector or watchdog enabled
// - idle on, sysclk-in-idle off: core off, fast osc off, sub/timebase on
// - idle on, sysclk-in-idle on: core off, system and sub clocks stay
// - idle off gives a stop mode, idle on gives an idle mode
// - detector enabled keeps detector and sub clock running
// - stop modes disable peripherals except watchdog and detector
// - clock select field picks sub clock or fast clock divided 64 to 2
// - high/low select set routes undivided fast clock to system
// - switching to sub clock stops the fast oscillator
// - slow ready low in deep stop; 1024 or 2 cycles after wake
// - fast ready low at reset, stop and core-off-sub; set when stable
// - normal mode clocks core from fast clock divided 1 to 64
// - mode control bit 4 reads zero
// - undefined sub source sets error flag; only software write 0 clears
// - system control bits 6 to 4 read zero
// - sub source 0101010 rc, 1010101 crystal, other values reset
module omcc_mode_ctrl
  import omcc_pkg::*;
#(
  parameter int FAST_STABLE = FAST_STABLE_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // core side
  input wire logic power_down,
  input wire logic wake_up,
  input wire logic watchdog_enable,
  input wire logic low_voltage_detect_enable,
  // clock gates
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic sys_clk_from_sub,
  output logic sub_clk_en,
  output logic time_base_clk_en,
  output logic fast_osc_en,
  output logic watchdog_run,
  output logic detector_run,
  output logic peripheral_en,
  output logic mcu_reset_req,
  // interrupt
  output logic irq
);
  logic [2:0] clock_select_field;
  logic high_low_clock_select;
  logic idle_enable;
  logic sysclk_in_idle;
  logic subclock_select_error_flag;
  logic low_voltage_reset_flag;
  logic lv_control_reset_flag;
  logic watchdog_control_reset_flag;
  logic [7:0] subclock_source_control;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_enable;
  logic [IRQ_N-1:0] events;
  omcc_mode_t mode;
  omcc_mode_t next_mode;
  logic fast_osc_ready;
  logic slow_osc_ready;
  logic fast_ready_q;
  logic slow_ready_q;
  logic sub_src_bad;
  logic sys_tick;
  logic from_sub;
  logic ack;
  logic wr_mode;
  logic wr_sys;
  logic wr_sub;
  logic wr_irq;
  logic [10:0] slow_cycles;
  logic [10:0] fast_cycles;

  // one wait state: request seen, then acknowledged on the next edge
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (read || write) && !ack;
  end

  assign waitrequest = (read || write) && !ack;
  assign wr_mode = write && ack && address == ADDR_MODE_CTRL && byteenable[0];
  assign wr_sys = write && ack && address == ADDR_SYS_CTRL && byteenable[0];
  assign wr_sub = write && ack && address == ADDR_SUB_SRC && byteenable[0];
  assign wr_irq = write && ack && address == ADDR_IRQ_STATUS;

  // mode control register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      clock_select_field <= MODE_CTRL_RESET[MC_CKS_LSB +: 3];
      idle_enable <= MODE_CTRL_RESET[MC_IDLE_EN];
      high_low_clock_select <= MODE_CTRL_RESET[MC_HIGH_LOW_CLOCK_SELECT];
    end
    else if (wr_mode)
    begin
      clock_select_field <= writedata[MC_CKS_LSB +: 3];
      idle_enable <= writedata[MC_IDLE_EN];
      high_low_clock_select <= writedata[MC_HIGH_LOW_CLOCK_SELECT];
    end
  end

  // system control register; reset flags are plain software bits here
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sysclk_in_idle <= 1'b0;
      low_voltage_reset_flag <= 1'b0;
      lv_control_reset_flag <= 1'b0;
      watchdog_control_reset_flag <= 1'b0;
    end
    else if (wr_sys)
    begin
      sysclk_in_idle <= writedata[SC_SYSCLK_IDLE];
      low_voltage_reset_flag <= writedata[SC_LVR];
      lv_control_reset_flag <= writedata[SC_LVCTL];
      watchdog_control_reset_flag <= writedata[SC_WDCTL];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      subclock_source_control <= SUB_SRC_RESET;
    else if (wr_sub)
      subclock_source_control <= writedata[7:0];
  end

  assign sub_src_bad = subclock_source_control[6:0] != SUB_SRC_RC &&
    subclock_source_control[6:0] != SUB_SRC_XTAL;
  assign mcu_reset_req = sub_src_bad;

  // set beats a software clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      subclock_select_error_flag <= 1'b0;
    else if (sub_src_bad)
      subclock_select_error_flag <= 1'b1;
    else if (wr_sys && !writedata[SC_SUB_ERR])
      subclock_select_error_flag <= 1'b0;
  end

  // power-down pulse sampled together with the enable bits
  always_comb
  begin
    next_mode = mode;
    case (mode)
      OMCC_RUN:
      begin
        if (power_down)
        begin
          if (!idle_enable)
          begin
            if (low_voltage_detect_enable || watchdog_enable)
              next_mode = OMCC_STOP_SUB;
            else
              next_mode = OMCC_DEEP_STOP;
          end
          else if (sysclk_in_idle)
            next_mode = OMCC_IDLE_SYS;
          else
            next_mode = OMCC_IDLE_SUB;
        end
      end
      OMCC_DEEP_STOP, OMCC_STOP_SUB, OMCC_IDLE_SUB, OMCC_IDLE_SYS:
      begin
        if (wake_up)
          next_mode = OMCC_RUN;
      end
      default: next_mode = OMCC_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      mode <= OMCC_RUN;
    else
      mode <= next_mode;
  end

  // fast oscillator off while on the sub clock and in the stop and sub idle modes
  always_comb
  begin
    fast_osc_en = 1'b0;
    case (mode)
      OMCC_RUN: fast_osc_en = !from_sub;
      OMCC_IDLE_SYS: fast_osc_en = !from_sub;
      default: fast_osc_en = 1'b0;
    endcase
  end

  always_comb
  begin
    cpu_clk_en = 1'b0;
    sys_clk_en = 1'b0;
    sub_clk_en = 1'b0;
    time_base_clk_en = 1'b0;
    watchdog_run = 1'b0;
    detector_run = low_voltage_detect_enable;
    peripheral_en = 1'b0;
    case (mode)
      OMCC_RUN:
      begin
        cpu_clk_en = sys_tick && (from_sub || fast_osc_ready);
        sys_clk_en = sys_tick && (from_sub || fast_osc_ready);
        sub_clk_en = 1'b1;
        time_base_clk_en = 1'b1;
        watchdog_run = watchdog_enable;
        peripheral_en = 1'b1;
      end
      OMCC_DEEP_STOP:
        sub_clk_en = low_voltage_detect_enable;
      OMCC_STOP_SUB:
      begin
        sub_clk_en = low_voltage_detect_enable || watchdog_enable;
        watchdog_run = watchdog_enable;
      end
      OMCC_IDLE_SUB:
      begin
        sub_clk_en = 1'b1;
        time_base_clk_en = 1'b1;
        watchdog_run = watchdog_enable;
        peripheral_en = 1'b1;
      end
      OMCC_IDLE_SYS:
      begin
        sys_clk_en = sys_tick;
        sub_clk_en = 1'b1;
        time_base_clk_en = 1'b1;
        watchdog_run = watchdog_enable;
        peripheral_en = 1'b1;
      end
      default:
        sub_clk_en = low_voltage_detect_enable;
    endcase
  end

  assign sys_clk_from_sub = from_sub;

  omcc_clock_divider u_div (
    .clock(clock),
    .rst(rst),
    .fast_on(fast_osc_ready),
    .high_low_clock_select(high_low_clock_select),
    .clock_select_field(clock_select_field),
    .sys_tick(sys_tick),
    .sys_from_sub(from_sub)
  );

  assign fast_cycles = (FAST_STABLE > 2047) ? 11'h7ff : 11'(FAST_STABLE);
  assign slow_cycles = subclock_source_control[6:0] == SUB_SRC_XTAL ?
    11'(SLOW_XTAL_CYCLES) : 11'(SLOW_RC_CYCLES);

  omcc_ready_timer u_fast (
    .clock(clock),
    .rst(rst),
    .run(fast_osc_en),
    .cycles(fast_cycles),
    .ready(fast_osc_ready)
  );

  omcc_ready_timer u_slow (
    .clock(clock),
    .rst(rst),
    .run(sub_clk_en),
    .cycles(slow_cycles),
    .ready(slow_osc_ready)
  );

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fast_ready_q <= 1'b0;
      slow_ready_q <= 1'b0;
    end
    else
    begin
      fast_ready_q <= fast_osc_ready;
      slow_ready_q <= slow_osc_ready;
    end
  end

  assign events[EV_PDOWN] = power_down && mode == OMCC_RUN;
  assign events[EV_FAST] = fast_osc_ready && !fast_ready_q;
  assign events[EV_SLOW] = slow_osc_ready && !slow_ready_q;
  assign events[EV_SUBERR] = sub_src_bad && !subclock_select_error_flag;

  // sticky status; a new event wins over the write-one clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_status <= '0;
    else if (wr_irq && byteenable[2])
      irq_status <= events |
        (irq_status & ~writedata[IRQ_CLEAR_LSB +: IRQ_N]);
    else
      irq_status <= irq_status | events;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_enable <= '0;
    else if (wr_irq && byteenable[1])
      irq_enable <= writedata[IRQ_ENABLE_LSB +: IRQ_N];
  end

  assign irq = |(irq_status & irq_enable);

  // unmapped addresses read zero; unimplemented bits read zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      readdata <= 32'h0000_0000;
    else
    begin
      readdata <= 32'h0000_0000;
      case (address)
        ADDR_MODE_CTRL:
          readdata[7:0] <= {clock_select_field, 1'b0,
            slow_osc_ready, fast_osc_ready, idle_enable,
            high_low_clock_select};
        ADDR_SYS_CTRL:
          readdata[7:0] <= {sysclk_in_idle, 3'h0,
            subclock_select_error_flag, low_voltage_reset_flag,
            lv_control_reset_flag, watchdog_control_reset_flag};
        ADDR_SUB_SRC:
          readdata[7:0] <= subclock_source_control;
        ADDR_IRQ_STATUS:
          readdata[IRQ_ENABLE_LSB + IRQ_N - 1:0] <= {irq_enable, 4'h0,
            irq_status};
        default:
          readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : omcc_mode_ctrl

/* omcc_pkg.sv */
package omcc_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SUB_SRC = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hc;
  // mode control fields
  localparam int MC_CKS_LSB = 5;
  localparam int MC_SLOW_RDY = 3;
  localparam int MC_FAST_RDY = 2;
  localparam int MC_IDLE_EN = 1;
  localparam int MC_HIGH_LOW_CLOCK_SELECT = 0;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h03;
  // system control fields
  localparam int SC_SYSCLK_IDLE = 7;
  localparam int SC_SUB_ERR = 3;
  localparam int SC_LVR = 2;
  localparam int SC_LVCTL = 1;
  localparam int SC_WDCTL = 0;
  // sub-clock source field plus low-power bit at 7
  localparam logic [6:0] SUB_SRC_RC = 7'h2a;
  localparam logic [6:0] SUB_SRC_XTAL = 7'h55;
  localparam logic [7:0] SUB_SRC_RESET = 8'h2a;
  // interrupt register offsets within status word
  localparam int IRQ_ENABLE_LSB = 8;
  localparam int IRQ_CLEAR_LSB = 16;
  localparam int IRQ_N = 4;
  // event bits: 0 power-down entry, 1 fast ready, 2 slow ready, 3 sub error
  localparam int EV_PDOWN = 0;
  localparam int EV_FAST = 1;
  localparam int EV_SLOW = 2;
  localparam int EV_SUBERR = 3;
  // timing
  localparam int SLOW_XTAL_CYCLES = 1024;
  localparam int SLOW_RC_CYCLES = 2;
  localparam int CLOCK_MHZ = 20;
  localparam int FAST_STABLE_US = 100;
  localparam int FAST_STABLE_CYCLES = FAST_STABLE_US * CLOCK_MHZ;
  typedef enum logic [2:0] {
    OMCC_RUN,
    OMCC_DEEP_STOP,
    OMCC_STOP_SUB,
    OMCC_IDLE_SUB,
    OMCC_IDLE_SYS
  } omcc_mode_t;
endpackage : omcc_pkg

/* omcc_ready_timer.sv */
`timescale 1ns/10ps
module omcc_ready_timer
  import omcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [10:0] cycles,
  // status
  output logic ready
);
  logic [10:0] count;

  // ready falls whenever run drops and rises on the cycles-th edge of run
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count <= 11'h000;
    else if (!run)
      count <= 11'h000;
    else if (count < cycles)
      count <= count + 11'h001;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ready <= 1'b0;
    else
      // twelve bits so a count saturated at 2047 cannot wrap to zero
      ready <= run && ({1'b0, count} + 12'h001 >= {1'b0, cycles});
  end
endmodule : omcc_ready_timer

/* omcc_clock_divider.sv */
`timescale 1ns/10ps
module omcc_clock_divider
  import omcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // selection
  input wire logic fast_on,
  input wire logic high_low_clock_select,
  input wire logic [2:0] clock_select_field,
  // output enables for the system clock
  output logic sys_tick,
  output logic sys_from_sub
);
  logic [5:0] prescale;
  logic [5:0] mask;

  // divider stops with the fast oscillator so no stale phase survives
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      prescale <= 6'h00;
    else if (!fast_on)
      prescale <= 6'h00;
    else
      prescale <= prescale + 6'h01;
  end

  always_comb
  begin
    case (clock_select_field)
      3'h2: mask = 6'h3f;
      3'h3: mask = 6'h1f;
      3'h4: mask = 6'h0f;
      3'h5: mask = 6'h07;
      3'h6: mask = 6'h03;
      3'h7: mask = 6'h01;
      default: mask = 6'h00;
    endcase
  end

  always_comb
  begin
    sys_from_sub = !high_low_clock_select && (clock_select_field[2:1] == 2'h0);
    if (high_low_clock_select)
      sys_tick = fast_on;
    else if (sys_from_sub)
      sys_tick = 1'b1;
    else
      sys_tick = fast_on && ((prescale & mask) == 6'h00);
  end
endmodule : omcc_clock_divider

/* omcc_checker_properties.sv */
`timescale 1ns/10ps
module omcc_checker
  import omcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // core side
  input wire logic power_down,
  input wire logic wake_up,
  input wire logic watchdog_enable,
  input wire logic low_voltage_detect_enable,
  // gates
  input wire logic cpu_clk_en,
  input wire logic sys_clk_from_sub,
  input wire logic sub_clk_en,
  input wire logic time_base_clk_en,
  input wire logic fast_osc_en,
  input wire logic watchdog_run,
  input wire logic detector_run,
  input wire logic peripheral_en,
  input wire logic mcu_reset_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic in_lp;
  logic take;
  logic bad_sub;
  logic idle_on;
  logic [7:0] mode_q;
  logic sys_idle_q;
  logic [6:0] sub_q;
  assign take = power_down && !in_lp;
  assign idle_on = mode_q[MC_IDLE_EN];
  assign bad_sub = sub_q != SUB_SRC_RC && sub_q != SUB_SRC_XTAL;
  // power-down only counts from run, so track the mode from the pulses
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      in_lp <= 1'b0;
    else if (wake_up)
      in_lp <= 1'b0;
    else if (power_down)
      in_lp <= 1'b1;
  end
  // shadow the whole mode byte, the sysclk-in-idle bit and the sub source field
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= MODE_CTRL_RESET;
      sys_idle_q <= 1'b0;
      sub_q <= SUB_SRC_RESET[6:0];
    end
    else if (write && !waitrequest && byteenable[0])
    begin
      if (address == ADDR_MODE_CTRL)
        mode_q <= writedata[7:0];
      if (address == ADDR_SYS_CTRL)
        sys_idle_q <= writedata[SC_SYSCLK_IDLE];
      if (address == ADDR_SUB_SRC)
        sub_q <= writedata[6:0];
    end
  end
  property p_deep;
    take && !idle_on && !low_voltage_detect_enable && !watchdog_enable
      |=> !sub_clk_en && !time_base_clk_en && !watchdog_run;
  endproperty
  a_deep: assert property (p_deep) else $error("deep stop clock on");
  property p_lvd;
    take && !idle_on && low_voltage_detect_enable |=> sub_clk_en && detector_run;
  endproperty
  a_lvd: assert property (p_lvd) else $error("detector stopped");
  property p_stop;
    take && !idle_on && (low_voltage_detect_enable || watchdog_enable)
      |=> sub_clk_en && !time_base_clk_en && !peripheral_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop gates wrong");
  property p_idle_sub;
    take && idle_on && !sys_idle_q
      |=> !fast_osc_en && sub_clk_en && time_base_clk_en;
  endproperty
  a_idle_sub: assert property (p_idle_sub) else $error("idle gates");
  property p_idle_sys;
    take && idle_on && sys_idle_q |=> sub_clk_en && time_base_clk_en;
  endproperty
  a_idle_sys: assert property (p_idle_sys) else $error("idle sys gates");
  property p_halted;
    in_lp |-> !cpu_clk_en;
  endproperty
  a_halted: assert property (p_halted) else $error("core clock in halt");
  property p_sub_sel;
    !in_lp && !mode_q[MC_HIGH_LOW_CLOCK_SELECT] && mode_q[7:6] == 2'b00
      |-> sys_clk_from_sub && !fast_osc_en;
  endproperty
  a_sub_sel: assert property (p_sub_sel) else $error("sub select");
  property p_fast_sel;
    !in_lp && (mode_q[MC_HIGH_LOW_CLOCK_SELECT] || mode_q[7:6] != 2'b00)
      |-> !sys_clk_from_sub && fast_osc_en;
  endproperty
  a_fast_sel: assert property (p_fast_sel) else $error("fast select");
  property p_sub_reset;
    mcu_reset_req == bad_sub;
  endproperty
  a_sub_reset: assert property (p_sub_reset) else $error("reset request");
  property p_bit4;
    read && !waitrequest && address == ADDR_MODE_CTRL |-> !readdata[4];
  endproperty
  a_bit4: assert property (p_bit4) else $error("mode bit 4 set");
  property p_bits64;
    read && !waitrequest && address == ADDR_SYS_CTRL |-> readdata[6:4] == 3'h0;
  endproperty
  a_bits64: assert property (p_bits64) else $error("sys bits 6-4 set");
endmodule : omcc_checker

/* omcc_core_model.sv */
`timescale 1ns/10ps
module omcc_core_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // commands from the bench
  input wire logic halt_req,
  input wire logic wake_req,
  // to the controller
  output logic power_down,
  output logic wake_up
);
  logic halt_d;
  logic wake_d;
  // each rising request edge becomes one single-cycle pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      halt_d <= 1'b0;
      wake_d <= 1'b0;
      power_down <= 1'b0;
      wake_up <= 1'b0;
    end
    else
    begin
      halt_d <= halt_req;
      wake_d <= wake_req;
      power_down <= halt_req && !halt_d;
      wake_up <= wake_req && !wake_d;
    end
  end
endmodule : omcc_core_model

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import omcc_pkg::*;
();
  logic clock, rst, read, write, halt_req, wake_req, waitrequest;
  logic watchdog_enable, low_voltage_detect_enable, power_down, wake_up;
  logic cpu_clk_en, sys_clk_en, sys_clk_from_sub, sub_clk_en, irq;
  logic time_base_clk_en, fast_osc_en, watchdog_run, detector_run;
  logic peripheral_en, mcu_reset_req;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, rdata, ticks;
  logic [10:0] modes [5];
  int fails, compares;
  omcc_mode_ctrl #(.FAST_STABLE(8)) omcc_mode_ctrl_i (.clock(clock),
    .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .power_down(power_down), .wake_up(wake_up),
    .watchdog_enable(watchdog_enable),
    .low_voltage_detect_enable(low_voltage_detect_enable),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .sys_clk_from_sub(sys_clk_from_sub), .sub_clk_en(sub_clk_en),
    .time_base_clk_en(time_base_clk_en), .fast_osc_en(fast_osc_en),
    .watchdog_run(watchdog_run), .detector_run(detector_run),
    .peripheral_en(peripheral_en), .mcu_reset_req(mcu_reset_req), .irq(irq));
  omcc_core_model omcc_core_model_i (.clock(clock), .rst(rst),
    .halt_req(halt_req), .wake_req(wake_req), .power_down(power_down),
    .wake_up(wake_up));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // the slave promises exactly one wait state per access
    chk("bus wait states", 32'h1, 32'(n - 1));
  endtask : bus
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'h1);
  endtask : wr8
  task automatic rd(input logic [3:0] a, input logic [7:0] mask,
    input logic [7:0] exp, input string name);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(name, {24'h0, exp}, {24'h0, rdata[7:0] & mask});
  endtask : rd
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (60000) @(posedge clock);
    fails++;
    finish_test();
  end
  initial
  begin
    // idle, sysclk-in-idle, lvd, wd | sub, timebase, fast, wd, det | ready
    modes = '{11'b0000_00000_00, 11'b0001_10010_10, 11'b0010_10001_10,
      11'b1000_11000_10, 11'b1100_11100_11};
    {rst, read, write, halt_req, wake_req} = 5'h10;
    {watchdog_enable, low_voltage_detect_enable} = 2'h0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    fails = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (20) @(posedge clock);
    rd(ADDR_MODE_CTRL, 8'hff, 8'h0f, "mode reset");
    rd(ADDR_SYS_CTRL, 8'hff, 8'h00, "sys reset");
    rd(ADDR_SUB_SRC, 8'hff, 8'h2a, "sub reset");
    rd(4'h6, 8'hff, 8'h00, "unmapped");
    wr8(ADDR_MODE_CTRL, 8'hff);
    rd(ADDR_MODE_CTRL, 8'hff, 8'hef, "mode bit4");
    wr8(ADDR_SYS_CTRL, 8'hf7);
    rd(ADDR_SYS_CTRL, 8'hff, 8'h87, "sys bits 6-4");
    wr8(ADDR_SYS_CTRL, 8'h00);
    for (int c = 2; c < 9; c++)
    begin
      wr8(ADDR_MODE_CTRL, (c == 8) ? 8'h01 : {c[2:0], 5'h0});
      repeat (20) @(posedge clock);
      ticks = 32'h0;
      repeat (128)
      begin
        @(posedge clock);
        ticks = ticks + {31'h0, sys_clk_en};
      end
      chk("sys ticks", 32'h80 >> (8 - c), ticks);
    end
    for (int c = 0; c < 2; c++)
    begin
      wr8(ADDR_MODE_CTRL, {c[2:0], 5'h0});
      @(posedge clock);
      chk("from sub", 32'h1, {31'h0, sys_clk_from_sub});
      chk("fast off", 32'h0, {31'h0, fast_osc_en});
    end
    wr8(ADDR_MODE_CTRL, 8'h01);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0800, 4'h2);
    wr8(ADDR_SUB_SRC, 8'h00);
    @(posedge clock);
    chk("reset req", 32'h1, {31'h0, mcu_reset_req});
    repeat (2) @(posedge clock);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(ADDR_SYS_CTRL, 8'h08, 8'h08, "sub err");
    wr8(ADDR_SUB_SRC, 8'h55);
    @(posedge clock);
    chk("reset req off", 32'h0, {31'h0, mcu_reset_req});
    rd(ADDR_SYS_CTRL, 8'h08, 8'h08, "sub err kept");
    wr8(ADDR_SYS_CTRL, 8'h00);
    rd(ADDR_SYS_CTRL, 8'h08, 8'h00, "sub err cleared");
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0, 4'h2);
    @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ADDR_IRQ_STATUS, 8'h08, 8'h08, "status sticky");
    bus(1'b1, ADDR_IRQ_STATUS, 32'h000f_0000, 4'h4);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0800, 4'h2);
    @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // crystal sub source now: give its ready count time before the modes
    repeat (1100) @(posedge clock);
    foreach (modes[i])
    begin
      wr8(ADDR_MODE_CTRL, {6'h0, modes[i][10], 1'b1});
      wr8(ADDR_SYS_CTRL, {modes[i][9], 7'h0});
      low_voltage_detect_enable <= modes[i][8];
      watchdog_enable <= modes[i][7];
      halt_req <= 1'b1;
      repeat (3) @(posedge clock);
      chk("gates", {27'h0, modes[i][6:2]}, {27'h0, sub_clk_en,
        time_base_clk_en, fast_osc_en, watchdog_run, detector_run});
      chk("core stopped", {30'h0, modes[i][9], 1'b0}, {30'h0, sys_clk_en,
        cpu_clk_en});
      halt_req <= 1'b0;
      wake_req <= 1'b1;
      repeat (3) @(posedge clock);
      wake_req <= 1'b0;
      rd(ADDR_MODE_CTRL, 8'h0c, {4'h0, modes[i][1:0], 2'h0}, "ready");
      repeat (1100) @(posedge clock);
      rd(ADDR_MODE_CTRL, 8'h0c, 8'h0c, "ready again");
    end
    // power-down, fast ready and slow ready events all seen since the clear
    rd(ADDR_IRQ_STATUS, 8'h0f, 8'h07, "status events");
    finish_test();
  end
endmodule : tb_top
bind omcc_mode_ctrl omcc_checker omcc_checker_i (.clock(clock), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .power_down(power_down), .wake_up(wake_up),
  .watchdog_enable(watchdog_enable),
  .low_voltage_detect_enable(low_voltage_detect_enable),
  .cpu_clk_en(cpu_clk_en), .sys_clk_from_sub(sys_clk_from_sub),
  .sub_clk_en(sub_clk_en), .time_base_clk_en(time_base_clk_en),
  .fast_osc_en(fast_osc_en), .watchdog_run(watchdog_run),
  .detector_run(detector_run), .peripheral_en(peripheral_en),
  .mcu_reset_req(mcu_reset_req));
